/* mdcs_defines.svh */
// Offsets, field positions, reset values and timing counts of the drive control block.
// Included by its bare name from the package, the top module and the bench.
`ifndef MDCS_DEFINES_SVH
`define MDCS_DEFINES_SVH

`define MDCS_OFS_DRIVE      8'h28
`define MDCS_OFS_STATUS     8'h40
`define MDCS_OFS_MASK       8'h44
`define MDCS_OFS_STATE      8'h48

`define MDCS_DRIVE_RESET    8'h00
`define MDCS_DRIVE_WMASK    8'h9f
`define MDCS_BIT_HYS_DIS    7
`define MDCS_BIT_ALM_CLR    6

`define MDCS_EV_OC          0
`define MDCS_EV_VGB         1
`define MDCS_EV_VGT         2
`define MDCS_EV_W           3

`define MDCS_CLK_NS         20
`define MDCS_DEAD_TIME_NS   500
`define MDCS_DEAD_CYCLES    ((`MDCS_DEAD_TIME_NS + `MDCS_CLK_NS - 1) / `MDCS_CLK_NS)

`define MDCS_RESP_OKAY      2'h0
`define MDCS_RESP_SLVERR    2'h2

`endif

/* mdcs_pkg.sv */
// Types shared by the drive control block.
// Assumes mdcs_defines.svh is on the include path.
`include "mdcs_defines.svh"

package mdcs_pkg;

  typedef struct packed {
    logic hysDisable;
    logic alarmClear;
    logic spare;
    logic driveMethodSelect;
    logic deadTimeBypass;
    logic ocResponseSelect;
    logic direction;
    logic runPermission;
  } mdcs_ctrl_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } mdcs_gate_t;

  typedef enum logic [1:0] {
    ST_STOPPED   = 2'b00,
    ST_DRIVING   = 2'b01,
    ST_PROTECTED = 2'b11
  } mdcs_state_t;

endpackage

/* mdcs_properties.sv */
// Checker of the drive control block, bound to its top module.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps
`default_nettype none
module mdcs_properties (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Bus handshakes.
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Alarms and drive stage.
  input wire logic        ocTrip,
  input wire logic        bottomPumpUndervoltage,
  input wire logic        topPumpUndervoltage,
  input wire logic [2:0]  hsGate,
  input wire logic [2:0]  lsGate,
  input wire logic        outputsHiZ
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_uv;
    bottomPumpUndervoltage || topPumpUndervoltage;
  endsequence
  sequence s_floating;
    outputsHiZ && hsGate == 3'h0 && lsGate == 3'h0;
  endsequence
  a_stop_undriven: assert property (
    outputsHiZ |-> (hsGate | lsGate) == 3'h0) else $error("Gates on while floating.");
  a_uv_floats: assert property (
    s_uv |-> ##2 s_floating) else $error("Undervoltage did not float the stage.");
  a_oc_high_off: assert property (
    ocTrip |-> ##3 hsGate == 3'h0) else $error("High side on after overcurrent.");
  a_no_overlap: assert property (
    (hsGate & lsGate) == 3'h0) else $error("Both sides of a leg on.");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("Read answer late.");
  // The bench master always holds its ready, so each answer closes at its first edge.
  a_b_stands: assert property (
    bvalid && bready |=> !bvalid && awready && wready && $stable(bresp))
    else $error("Write response not closed.");
  a_r_stands: assert property (
    rvalid && rready |=> !rvalid && arready && $stable(rdata) && $stable(rresp))
    else $error("Read response not closed.");
  a_write_busy: assert property (
    bvalid |-> !awready && !wready) else $error("Write taken during response.");
endmodule
bind mdcs_top mdcs_properties chk_u (.clk, .rst, .awready, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .ocTrip,
  .bottomPumpUndervoltage, .topPumpUndervoltage, .hsGate, .lsGate, .outputsHiZ);
`default_nettype wire

/* mdcs_stage_model.sv */
// Power stage model: reports which phase legs the gate drives switch on.
// Assumes gate drives are high while a transistor is on; both off leaves the leg floating.
`timescale 1ns/100ps
`default_nettype none
module mdcs_stage_model (
  // Gate drives from the block.
  input  wire logic [2:0] hsGate,
  input  wire logic [2:0] lsGate,
  // Leg state seen by the motor.
  output logic      [2:0] driven,
  output logic            overlap
);
  assign driven  = hsGate | lsGate;
  assign overlap = |(hsGate & lsGate);
endmodule
`default_nettype wire

/* mdcs_top.sv */
// Motor drive control setting block: drive byte, protection latch and gate output stage.
// Assumes a single 50 MHz clock; all inputs are synchronous to it.
//
// Overview of operation
// (RL1) Alarm clear write releases protection, resumes drive.
// (RL2) Protection stays latched until alarm clear written.
// (RL3) Protected outputs are Hi-Z or low brake.
// (RL4) Overcurrent: select 0 Hi-Z, 1 low brake.
// (RL5) Other alarms force Hi-Z over brake choice.
// (RL6) Hysteresis on overcurrent unless disable bit set.
// (RL7) Method bit: 0 normal PWM, 1 commutation.
// (RL8) Software avoids commutation under sensorless control.
// (RL9) Dead time inserted unless bypass bit set.
// (RL10) Direction bit: 0 clockwise, 1 counter-clockwise.
// (RL11) Run permission 0 keeps motor undriven; an overcurrent with the brake select bit set still turns the low sides on.
// (RL12) Software keeps lock wait fixed while driving.
// (RL13) Alarm clear is a write-one action.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mdcs_defines.svh"

module mdcs_top #(
  parameter int ADDR_W       = 8,
  parameter int DEAD_TIME_NS = `MDCS_DEAD_TIME_NS
) (
  // Clock, reset and enable.
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Alarm inputs from the comparators.
  input  wire logic               ocTrip,
  input  wire logic               ocRelease,
  input  wire logic               bottomPumpUndervoltage,
  input  wire logic               topPumpUndervoltage,
  // Host phase commands, index 0 to 2 for phases U, V, W.
  input  wire logic [2:0]         hsCmd,
  input  wire logic [2:0]         lsCmd,
  // Drive stage and status.
  output logic [2:0]              hsGate,
  output logic [2:0]              lsGate,
  output logic                    outputsHiZ,
  output logic                    irq
);

  localparam int DEAD_CYCLES = (DEAD_TIME_NS + `MDCS_CLK_NS - 1) / `MDCS_CLK_NS;
  localparam int CNT_W = $clog2(DEAD_CYCLES + 1);
  localparam logic [CNT_W-1:0] DEAD_MAX = CNT_W'(DEAD_CYCLES);

  if (ADDR_W < 7 || ADDR_W > 32 || DEAD_TIME_NS < 1) begin : g_bad_params
    $error("mdcs_top: ADDR_W must be 7 to 32 and DEAD_TIME_NS positive");
  end

  // Bus slave state.
  logic [ADDR_W-1:0]           wAddr, next_wAddr;
  logic [31:0]                 wData, next_wData;
  logic [3:0]                  wStrb, next_wStrb;
  logic                        next_awready, next_wready, next_bvalid;
  logic [1:0]                  next_bresp;
  logic                        next_arready, next_rvalid;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;
  logic                        doWrite, doRead;

  // Register state.
  mdcs_pkg::mdcs_ctrl_t        ctrl, next_ctrl;
  logic [`MDCS_EV_W-1:0]       status, next_status;
  logic [`MDCS_EV_W-1:0]       mask, next_mask;
  logic                        next_irq;
  logic                        clearPulse;

  // Protection state.
  mdcs_pkg::mdcs_state_t       state, next_state;
  mdcs_pkg::mdcs_state_t       runState;
  logic                        ocDet, next_ocDet;
  logic                        latchOc, next_latchOc;
  logic                        latchUv, next_latchUv;
  logic                        ocPrev, vgbPrev, vgtPrev;
  logic [`MDCS_EV_W-1:0]       events;
  logic                        alarmNow;
  logic                        next_hiZ;

  // Gate request path.
  mdcs_pkg::mdcs_gate_t        cmd, req;

  assign doWrite = !awready && !wready && !bvalid;
  assign doRead  = arvalid && arready;
  assign clearPulse = doWrite && (wAddr == ADDR_W'(`MDCS_OFS_DRIVE)) && wStrb[0]
                      && wData[`MDCS_BIT_ALM_CLR];  // see (RL13)

  // Write address and data are taken in either order; the answer follows both.
  always_comb begin
    next_wAddr   = wAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (awvalid && awready) begin
      next_wAddr   = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_wData  = wdata;
      next_wStrb  = wstrb;
      next_wready = 1'b0;
    end
    if (doWrite) begin
      next_bvalid = 1'b1;
      case (wAddr)
        ADDR_W'(`MDCS_OFS_DRIVE),
        ADDR_W'(`MDCS_OFS_STATUS),
        ADDR_W'(`MDCS_OFS_MASK):  next_bresp = `MDCS_RESP_OKAY;
        default:                  next_bresp = `MDCS_RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
  end

  // Reads answer one cycle after the address is taken.
  always_comb begin
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (doRead) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = `MDCS_RESP_OKAY;
      case (araddr)
        ADDR_W'(`MDCS_OFS_DRIVE):  next_rdata = {24'h000000, ctrl};
        ADDR_W'(`MDCS_OFS_STATUS): next_rdata = {29'h00000000, status};
        ADDR_W'(`MDCS_OFS_MASK):   next_rdata = {29'h00000000, mask};
        ADDR_W'(`MDCS_OFS_STATE):  next_rdata = {26'h0000000, outputsHiZ, latchUv,
                                                 latchOc, ocDet, state};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `MDCS_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wAddr   <= '0;
      wData   <= 32'h00000000;
      wStrb   <= 4'h0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `MDCS_RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `MDCS_RESP_OKAY;
    end else if (ce) begin
      wAddr   <= next_wAddr;
      wData   <= next_wData;
      wStrb   <= next_wStrb;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Control, status and mask registers; a new event beats a clear in the same cycle.
  always_comb begin
    next_ctrl   = ctrl;
    next_status = status | events;
    next_mask   = mask;
    if (doWrite && wStrb[0]) begin
      case (wAddr)
        ADDR_W'(`MDCS_OFS_DRIVE):  next_ctrl = mdcs_pkg::mdcs_ctrl_t'(wData[7:0]
                                               & `MDCS_DRIVE_WMASK);  // see (RL13)
        ADDR_W'(`MDCS_OFS_STATUS): next_status = (status & ~wData[`MDCS_EV_W-1:0]) | events;
        ADDR_W'(`MDCS_OFS_MASK):   next_mask = wData[`MDCS_EV_W-1:0];
        default:                   next_mask = mask;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl   <= mdcs_pkg::mdcs_ctrl_t'(`MDCS_DRIVE_RESET);
      status <= 3'h0;
      mask   <= 3'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      ctrl   <= next_ctrl;
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end

  // Alarm detection and the protection latch.
  assign events[`MDCS_EV_OC]  = ocDet && !ocPrev;
  assign events[`MDCS_EV_VGB] = bottomPumpUndervoltage && !vgbPrev;
  assign events[`MDCS_EV_VGT] = topPumpUndervoltage && !vgtPrev;
  assign alarmNow = ocDet || bottomPumpUndervoltage || topPumpUndervoltage;

  always_comb begin
    if (ctrl.hysDisable) begin
      next_ocDet = ocTrip;  // see (RL6)
    end else if (ocTrip) begin
      next_ocDet = 1'b1;  // see (RL6)
    end else if (ocRelease) begin
      next_ocDet = 1'b0;
    end else begin
      next_ocDet = ocDet;
    end
    // A clear written while the alarm still stands leaves the latch set.
    next_latchOc = (latchOc && !clearPulse) || ocDet;  // see (RL1) see (RL2)
    next_latchUv = (latchUv && !clearPulse) || bottomPumpUndervoltage
                   || topPumpUndervoltage;  // see (RL1) see (RL2)
    runState = ctrl.runPermission ? mdcs_pkg::ST_DRIVING : mdcs_pkg::ST_STOPPED;
    case (state)
      mdcs_pkg::ST_STOPPED:   next_state = runState;
      mdcs_pkg::ST_DRIVING:   next_state = alarmNow ? mdcs_pkg::ST_PROTECTED : runState;
      mdcs_pkg::ST_PROTECTED: next_state = (next_latchOc || next_latchUv) ? mdcs_pkg::ST_PROTECTED
                                                                          : runState;
      default:                next_state = mdcs_pkg::ST_STOPPED;
    endcase
    if (alarmNow) begin
      next_state = mdcs_pkg::ST_PROTECTED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ocDet   <= 1'b0;
      ocPrev  <= 1'b0;
      vgbPrev <= 1'b0;
      vgtPrev <= 1'b0;
      latchOc <= 1'b0;
      latchUv <= 1'b0;
      state   <= mdcs_pkg::ST_STOPPED;
    end else if (ce) begin
      ocDet   <= next_ocDet;
      ocPrev  <= ocDet;
      vgbPrev <= bottomPumpUndervoltage;
      vgtPrev <= topPumpUndervoltage;
      latchOc <= next_latchOc;
      latchUv <= next_latchUv;
      state   <= next_state;
    end
  end

  // Gate requests: direction, drive method and the forced states.
  always_comb begin
    if (ctrl.direction) begin
      cmd.high = {hsCmd[1], hsCmd[2], hsCmd[0]};  // see (RL10)
      cmd.low  = {lsCmd[1], lsCmd[2], lsCmd[0]};
    end else begin
      cmd.high = hsCmd;
      cmd.low  = lsCmd;
    end
    req.high = cmd.high;
    if (ctrl.driveMethodSelect) begin
      req.low = (cmd.low | ~cmd.high) & ~cmd.high;  // see (RL7)
    end else begin
      req.low = cmd.low & ~cmd.high;  // see (RL7)
    end
    next_hiZ = 1'b0;
    case (state)
      mdcs_pkg::ST_DRIVING: begin
        next_hiZ = 1'b0;
      end
      mdcs_pkg::ST_PROTECTED: begin
        req.high = 3'h0;  // see (RL3)
        if (latchUv || !ctrl.ocResponseSelect) begin
          req.low  = 3'h0;  // see (RL4) see (RL5)
          next_hiZ = 1'b1;
        end else begin
          req.low  = 3'h7;  // see (RL4)
        end
      end
      default: begin
        req.high = 3'h0;  // see (RL11)
        req.low  = 3'h0;
        next_hiZ = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outputsHiZ <= 1'b1;
    end else if (ce) begin
      outputsHiZ <= next_hiZ;
    end
  end

  // Per phase output stage with dead time between the two sides.
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      logic [CNT_W-1:0] offCnt, next_offCnt;
      logic             next_hs, next_ls;

      always_comb begin
        if (ctrl.deadTimeBypass) begin
          next_hs = req.high[ph];  // see (RL9)
          next_ls = req.low[ph];
        end else begin
          next_hs = req.high[ph] && (hsGate[ph] || (!lsGate[ph] && offCnt == DEAD_MAX));
          next_ls = req.low[ph] && (lsGate[ph] || (!hsGate[ph] && offCnt == DEAD_MAX));
        end
        if (hsGate[ph] || lsGate[ph]) begin
          next_offCnt = '0;  // see (RL9)
        end else if (offCnt != DEAD_MAX) begin
          next_offCnt = offCnt + CNT_W'(1);
        end else begin
          next_offCnt = offCnt;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          offCnt      <= '0;
          hsGate[ph]  <= 1'b0;
          lsGate[ph]  <= 1'b0;
        end else if (ce) begin
          offCnt      <= next_offCnt;
          hsGate[ph]  <= next_hs;
          lsGate[ph]  <= next_ls;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* testbench.sv */
// Self-checking bench of the drive control block over AXI4-Lite.
// Assumes the package, design, stage model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "mdcs_defines.svh"
module testbench;
  localparam logic [7:0] DRV = `MDCS_OFS_DRIVE;
  localparam logic [7:0] STS = `MDCS_OFS_STATUS;
  localparam logic [7:0] MSK = `MDCS_OFS_MASK;
  logic        clk, rst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, outputsHiZ, overlap;
  logic        ocTrip, ocRelease, bottomPumpUndervoltage, topPumpUndervoltage;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  hsCmd, lsCmd, hsGate, lsGate, driven;
  int          bad_count, checks_done, cycles;
  mdcs_top dut_u (.clk, .rst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ocTrip, .ocRelease, .bottomPumpUndervoltage,
    .topPumpUndervoltage, .hsCmd, .lsCmd, .hsGate, .lsGate, .outputsHiZ, .irq);
  mdcs_stage_model stage_u (.hsGate, .lsGate, .driven, .overlap);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs();
    rdr(DRV);
    chk("drive reset", rd, `MDCS_DRIVE_RESET);
    chk("read resp", rs, `MDCS_RESP_OKAY);
    rdr(`MDCS_OFS_STATE);
    chk("state reset", rd, 32'h20);
    rdr(8'h10);
    chk("unmapped resp", rs, `MDCS_RESP_SLVERR);
    wr(`MDCS_OFS_STATE, 8'h01);
    chk("read only resp", rs, `MDCS_RESP_SLVERR);
    wr(MSK, 8'h00);
    chk("write resp", rs, `MDCS_RESP_OKAY);
  endtask
  // Commutation is chosen only under sensored drive, and no lock wait setting exists here.
  task automatic t_drive();
    hsCmd <= 3'h1;
    wr(DRV, 8'h09);
    idle(3);
    chk("bypass high", hsGate, 3'h1);
    chk("normal low", lsGate, 3'h0);
    wr(DRV, 8'h19);
    idle(3);
    chk("commutation low", lsGate, 3'h6);
    chk("overlap", overlap, 1'b0);
    hsCmd <= 3'h2;
    wr(DRV, 8'h0b);
    idle(3);
    chk("ccw high", hsGate, 3'h4);
    hsCmd <= 3'h0;
    lsCmd <= 3'h1;
    wr(DRV, 8'h08);
    idle(3);
    chk("stopped legs", driven, 3'h0);
    chk("stopped float", outputsHiZ, 1'b1);
    wr(DRV, 8'h01);
    idle(40);
    hsCmd <= 3'h1;
    lsCmd <= 3'h0;
    idle(10);
    chk("dead gap", hsGate, 3'h0);
    idle(30);
    chk("after gap", hsGate, 3'h1);
    // With the enable low a changed command must not reach the gates.
    ce <= 1'b0;
    hsCmd <= 3'h0;
    idle(3);
    chk("frozen gate", hsGate, 3'h1);
    ce <= 1'b1;
    hsCmd <= 3'h1;
  endtask
  task automatic t_prot();
    wr(MSK, 8'h07);
    wr(DRV, 8'h0d);
    ocTrip <= 1'b1;
    idle(1);
    ocTrip <= 1'b0;
    ocRelease <= 1'b1;
    idle(5);
    ocRelease <= 1'b0;
    chk("brake high", hsGate, 3'h0);
    chk("brake low", lsGate, 3'h7);
    chk("irq set", irq, 1'b1);
    wr(DRV, 8'h0d);
    idle(3);
    chk("kept brake", lsGate, 3'h7);
    wr(DRV, 8'h4d);
    idle(3);
    chk("resumed", hsGate, 3'h1);
    rdr(DRV);
    chk("clear reads 0", rd, 32'h0d);
    rdr(STS);
    chk("status", rd, 32'h1);
    wr(STS, 8'h01);
    idle(3);
    chk("irq clear", irq, 1'b0);
  endtask
  task automatic t_uv();
    for (int i = 0; i < 2; i++) begin
      wr(MSK, i ? 8'h00 : 8'h07);
      {topPumpUndervoltage, bottomPumpUndervoltage} <= i ? 2'b10 : 2'b01;
      idle(1);
      {topPumpUndervoltage, bottomPumpUndervoltage} <= 2'b00;
      idle(4);
      chk("uv float", outputsHiZ, 1'b1);
      chk("uv low", lsGate, 3'h0);
      chk("uv irq", irq, i ? 1'b0 : 1'b1);
      wr(STS, 8'h06);
      wr(DRV, 8'h4d);
      idle(3);
      chk("uv resumed", hsGate, 3'h1);
    end
  endtask
  task automatic t_oc();
    for (int i = 0; i < 2; i++) begin
      wr(DRV, i ? 8'h89 : 8'h09);
      ocTrip <= 1'b1;
      idle(1);
      ocTrip <= 1'b0;
      idle(4);
      chk("oc float", outputsHiZ, 1'b1);
      rdr(`MDCS_OFS_STATE);
      chk("oc state", rd, i ? 32'h2b : 32'h2f);
      ocRelease <= 1'b1;
      idle(2);
      ocRelease <= 1'b0;
      wr(DRV, i ? 8'hc9 : 8'h49);
      idle(3);
      chk("oc resumed", hsGate, 3'h1);
      wr(STS, 8'h01);
    end
  endtask
  initial begin
    {ce, rst} = 2'b11;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    wstrb = 4'h1;
    {ocTrip, ocRelease, bottomPumpUndervoltage, topPumpUndervoltage} = 4'h0;
    {hsCmd, lsCmd} = 6'h00;
    {cycles, bad_count, checks_done} = '0;
    idle(20);
    rst <= 1'b0;
    idle(1);
    t_regs();
    t_drive();
    t_prot();
    t_uv();
    t_oc();
    results();
  end
endmodule
`default_nettype wire
